// [src/seslg_top.sv]
// standard event status register, its enable mask and event summary bit
// assumes a command decoder giving one-cycle strobes on clk
`timescale 1ns/1ns
`default_nettype none

module seslg_top
  import seslg_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     cls_stb,
  input  wire logic                     ese_wr_stb,
  input  wire logic [seslg_pkg::SES_W-1:0] ese_wdata,
  input  wire logic                     ese_rd_stb,
  input  wire logic                     status_rd_stb,
  input  wire logic [7:0]               err_reg,
  input  wire logic                     queue_overflow,
  input  wire logic                     queue_empty_read,
  input  wire logic                     talk_before_rx_done,
  input  wire logic                     listen_before_tx_done,
  input  wire logic                     opc_cmd_stb,
  input  wire logic                     ops_idle,
  input  wire logic                     param_wr_stb,
  input  wire logic [7:0]               param_wdata,
  output logic [seslg_pkg::SES_W-1:0]   rdata_r,
  output logic                          rvalid_r,
  output logic [7:0]                    status_byte_esb_r,
  output logic                          clear_others_r,
  output logic [7:0]                    param_r
);
  import seslg_pkg::*;

  logic [7:0] ses_r;
  logic [7:0] ese_r;
  logic       opc_pend_r;
  logic       cme_src;
  logic       exe_src;
  logic       dde_src;
  logic       qye_evt;
  logic       opc_evt;
  logic [7:0] set_vec;
  logic [7:0] ses_nxt;
  logic [7:0] ese_nxt;

  assign cme_src = err_reg[ERR_MSG_LEN] | err_reg[ERR_HEADER]
                 | err_reg[ERR_FORMAT];
  assign exe_src = err_reg[ERR_RANGE] | err_reg[ERR_CANNOT];
  assign dde_src = err_reg[ERR_SERIAL] | err_reg[ERR_RAM];
  assign qye_evt = queue_overflow | queue_empty_read
                 | talk_before_rx_done | listen_before_tx_done;
  assign opc_evt = opc_pend_r & ops_idle;

  // mask seen by the summary on the same edge that stores it
  always_comb begin
    ese_nxt = ese_r;
    if (ese_wr_stb) begin
      ese_nxt = ese_wdata;
    end
  end

  always_comb begin
    set_vec          = 8'h00;
    set_vec[BIT_CME] = cme_src;
    set_vec[BIT_EXE] = exe_src;
    set_vec[BIT_QYE] = qye_evt;
    set_vec[BIT_OPC] = opc_evt;
    ses_nxt          = ses_r;
    if (cls_stb || status_rd_stb) begin
      ses_nxt = 8'h00;
    end
    ses_nxt          = ses_nxt | set_vec;  // new events win over clear
    ses_nxt[BIT_DDE] = dde_src;
    ses_nxt[BIT_URQ] = 1'b0;
    ses_nxt[BIT_RQC] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ses_r <= SES_RST;
    end else begin
      ses_r <= ses_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ese_r <= ESE_RST;
    end else if (ese_wr_stb) begin
      ese_r <= ese_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      opc_pend_r <= 1'b0;
    end else if (opc_cmd_stb) begin
      opc_pend_r <= 1'b1;
    end else if (opc_evt) begin
      opc_pend_r <= 1'b0;
    end
  end

  // parameters are replaced only when no format or range error came in
  always_ff @(posedge clk) begin
    if (srst) begin
      param_r <= PARAM_RST;
    end else if (param_wr_stb && !err_reg[ERR_FORMAT]
                 && !err_reg[ERR_RANGE]) begin
      param_r <= param_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= status_rd_stb | ese_rd_stb;
      if (status_rd_stb) begin
        rdata_r <= ses_r;
      end else if (ese_rd_stb) begin
        rdata_r <= ese_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      status_byte_esb_r <= 8'h00;
      clear_others_r    <= 1'b0;
    end else begin
      status_byte_esb_r          <= 8'h00;
      status_byte_esb_r[STB_ESB] <= |(ses_nxt & ese_nxt);
      clear_others_r             <= cls_stb;
    end
  end

  // checks on what this block drives
  a_read_clears: assert property (@(posedge clk) disable iff (srst)
    status_rd_stb && !(|set_vec) |=> (ses_r & 8'hF7) == 8'h00)
    else $error("status read did not clear");
  a_read_value: assert property (@(posedge clk) disable iff (srst)
    status_rd_stb |=> rvalid_r && rdata_r == $past(ses_r))
    else $error("status read value wrong");
  a_cls_clears: assert property (@(posedge clk) disable iff (srst)
    cls_stb && !(|set_vec)
    |=> (ses_r & 8'hF7) == 8'h00 && clear_others_r)
    else $error("clear status failed");
  a_ese_echo: assert property (@(posedge clk) disable iff (srst)
    ese_wr_stb ##1 ese_rd_stb && !status_rd_stb
    |=> rdata_r == $past(ese_wdata, 2))
    else $error("enable mask echo wrong");
  a_ese_store: assert property (@(posedge clk) disable iff (srst)
    ese_wr_stb |=> ese_r == $past(ese_wdata))
    else $error("enable mask not stored");
  a_cme_set: assert property (@(posedge clk) disable iff (srst)
    cme_src |=> ses_r[BIT_CME])
    else $error("command error not set");
  a_exe_set: assert property (@(posedge clk) disable iff (srst)
    exe_src |=> ses_r[BIT_EXE])
    else $error("execution error not set");
  a_dde_follow: assert property (@(posedge clk) disable iff (srst)
    ##1 ses_r[BIT_DDE] == $past(dde_src))
    else $error("device error not following cause");
  a_qye_set: assert property (@(posedge clk) disable iff (srst)
    qye_evt |=> ses_r[BIT_QYE])
    else $error("query error not set");
  a_opc_set: assert property (@(posedge clk) disable iff (srst)
    opc_cmd_stb ##1 ops_idle |=> ses_r[BIT_OPC])
    else $error("operation complete not set");
  a_esb_value: assert property (@(posedge clk) disable iff (srst)
    ##1 status_byte_esb_r[STB_ESB] == |(ses_r & ese_r))
    else $error("summary bit wrong");
  a_esb_only: assert property (@(posedge clk) disable iff (srst)
    (status_byte_esb_r & 8'hDF) == 8'h00)
    else $error("status byte stray bits");
  a_unused_zero: assert property (@(posedge clk) disable iff (srst)
    !ses_r[BIT_URQ] && !ses_r[BIT_RQC])
    else $error("unused bits set");
  a_param_keep: assert property (@(posedge clk) disable iff (srst)
    param_wr_stb && (err_reg[ERR_FORMAT] || err_reg[ERR_RANGE])
    |=> $stable(param_r))
    else $error("bad parameters stored");
  a_param_take: assert property (@(posedge clk) disable iff (srst)
    param_wr_stb && !err_reg[ERR_FORMAT] && !err_reg[ERR_RANGE]
    |=> param_r == $past(param_wdata))
    else $error("good parameters not stored");
  a_rvalid_pulse: assert property (@(posedge clk) disable iff (srst)
    !status_rd_stb && !ese_rd_stb |=> !rvalid_r)
    else $error("answer valid without query");
  a_clear_pulse: assert property (@(posedge clk) disable iff (srst)
    !cls_stb |=> !clear_others_r)
    else $error("clear request without command");
  a_pon_reset: assert property (@(posedge clk)
    srst |=> ses_r[BIT_PON])
    else $error("power-on bit not set");

  c_status_read: cover property (@(posedge clk)
    status_rd_stb && ses_r != 8'h00);
  c_esb_rise: cover property (@(posedge clk)
    $rose(status_byte_esb_r[STB_ESB]));
  c_opc_done: cover property (@(posedge clk) opc_evt);
  c_cls_event: cover property (@(posedge clk) cls_stb && qye_evt);
  c_param_drop: cover property (@(posedge clk)
    param_wr_stb && err_reg[ERR_FORMAT]);
endmodule : seslg_top

`default_nettype wire

// [src/seslg_pkg.sv]
// standard event status logic: bit positions, reset values, error register bit positions
// assumes an 8-bit status register fed by a command decoder elsewhere
package seslg_pkg;
  localparam int          SES_W        = 8;
  localparam int          BIT_PON      = 7;
  localparam int          BIT_URQ      = 6;
  localparam int          BIT_CME      = 5;
  localparam int          BIT_EXE      = 4;
  localparam int          BIT_DDE      = 3;
  localparam int          BIT_QYE      = 2;
  localparam int          BIT_RQC      = 1;
  localparam int          BIT_OPC      = 0;
  localparam int          STB_ESB      = 5;
  // error register bit positions
  localparam int          ERR_MSG_LEN  = 6;
  localparam int          ERR_HEADER   = 5;
  localparam int          ERR_FORMAT   = 4;
  localparam int          ERR_RANGE    = 3;
  localparam int          ERR_CANNOT   = 2;
  localparam int          ERR_SERIAL   = 1;
  localparam int          ERR_RAM      = 0;
  localparam logic [7:0]  SES_RST      = 8'h80;
  localparam logic [7:0]  ESE_RST      = 8'h00;
  localparam logic [7:0]  PARAM_RST    = 8'h00;
endpackage : seslg_pkg

// [testbench/seslg_ctrl_model.sv]
// controller model: issues the common command strobes
// assumes the bench calls send from its falling-edge driver
`timescale 1ns/1ns
`default_nettype none
module seslg_ctrl_model (
  input  wire logic       clk,
  output var  logic [4:0] stb,
  output var  logic [7:0] wdata
);
  initial begin
    stb = 5'h0;
    wdata = 8'h00;
  end
  // k: 0 clear, 1 mask write, 2 mask query, 3 status query, 4 complete
  task automatic send(input int k, input logic [7:0] d);
    @(negedge clk);
    stb[k] = 1'b1;
    wdata = d;
    @(negedge clk);
    stb = 5'h0;
    wdata = ~d;
  endtask : send
endmodule : seslg_ctrl_model
`default_nettype wire

// [testbench/tb_standard_event_status_logic.sv]
// bench for the standard event status logic
// assumes seslg_top and the controller model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_standard_event_status_logic;
  logic       clk = 0, srst = 1, idle = 0, pwr = 0, rv, clo;
  logic [7:0] err = 0, par = 0, rd, esb, prm, wd, m;
  logic [3:0] ev = 0;
  logic [4:0] s;
  logic [7:0] exp_q[$];
  int         fails = 0, total_checks = 0;
  always #5 clk = ~clk;
  seslg_ctrl_model CTL (.clk(clk), .stb(s), .wdata(wd));
  seslg_top DUT (.clk(clk), .srst(srst), .cls_stb(s[0]),
    .ese_wr_stb(s[1]), .ese_wdata(wd), .ese_rd_stb(s[2]),
    .status_rd_stb(s[3]), .err_reg(err), .queue_overflow(ev[0]),
    .queue_empty_read(ev[1]), .talk_before_rx_done(ev[2]),
    .listen_before_tx_done(ev[3]), .opc_cmd_stb(s[4]),
    .ops_idle(idle), .param_wr_stb(pwr), .param_wdata(par),
    .rdata_r(rd), .rvalid_r(rv), .status_byte_esb_r(esb),
    .clear_others_r(clo), .param_r(prm));
  task automatic end_sim();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // answers are compared in arrival order
  always @(negedge clk) if (rv === 1'b1) begin
    if (exp_q.size() != 0) chk(rd, exp_q.pop_front());
    else begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, rd, 8'h00);
    end
  end
  task automatic query(input int k, input logic [7:0] e);
    exp_q.push_back(e);
    CTL.send(k, 8'h00);
    @(negedge clk);
    if (exp_q.size() != 0) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, rd, e);
      end_sim();
    end
  endtask : query
  task automatic ev_pulse(input int i);
    @(negedge clk);
    ev[i] = 1'b1;
    @(negedge clk);
    ev = 4'h0;
  endtask : ev_pulse
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hb6b6_97ac));
    repeat (5) @(negedge clk);
    srst = 0;
    query(3, 8'h80);
    query(3, 8'h00);
    for (int i = 0; i < 4; i++) begin
      m = 8'($urandom);
      m[2] = i[0];
      CTL.send(1, m);
      query(2, m);
      ev_pulse(i);
      chk(esb, {2'b00, m[2], 5'b00000});
      query(3, 8'h04);
    end
    for (int i = 0; i < 7; i++) begin
      m = i > 3 ? 8'h20 : (i > 1 ? 8'h10 : 8'h08);
      err = 8'h01 << i;
      query(3, m);
      err = 8'h00;
      query(3, i < 2 ? 8'h00 : m);
    end
    CTL.send(4, 8'h00);
    repeat (3) @(negedge clk);
    query(3, 8'h00);
    idle = 1;
    repeat (2) @(negedge clk);
    idle = 0;
    query(3, 8'h01);
    // complete command while already idle
    idle = 1;
    CTL.send(4, 8'h00);
    @(negedge clk);
    idle = 0;
    query(3, 8'h01);
    ev_pulse(1);
    CTL.send(0, 8'h00);
    chk({7'h00, clo}, 8'h01);
    query(3, 8'h00);
    // second reset in mid-run brings power-on back
    srst = 1;
    repeat (2) @(negedge clk);
    srst = 0;
    query(3, 8'h80);
    m = 8'($urandom);
    for (int j = 0; j < 3; j++) begin
      @(negedge clk);
      err = j == 1 ? 8'h10 : (j == 2 ? 8'h08 : 8'h00);
      par = m ^ 8'(j);
      pwr = 1;
      @(negedge clk);
      pwr = 0;
      err = 8'h00;
      chk(prm, m);
    end
    end_sim();
  end
endmodule : tb_standard_event_status_logic
`default_nettype wire
